/* File: core/cmp_ctrl_cfg.svh */
// constants for the comparator control block: offsets, bit positions, resets
// assumes inclusion by bare name from the design and bench files
`ifndef CMP_CTRL_CFG_SVH
`define CMP_CTRL_CFG_SVH

// register indices; the byte address is four times the index
`define IDX_INPUT_DISABLE     8'h01
`define IDX_CONV_CONTROL_B    8'h03
`define IDX_CMP_STATUS        8'h08
`define IDX_CONV_CONTROL_A    8'h10
`define IDX_CONV_MUX_SELECT   8'h11
`define IDX_CPU_FLAGS         8'h12
`define ADDR_OF(idx)          ({(idx), 2'b00})

// comparator control status bit positions
`define BIT_CMP_DISABLE       7
`define BIT_BANDGAP_SELECT    6
`define BIT_CMP_RESULT        5
`define BIT_CMP_IRQ_FLAG      4
`define BIT_CMP_IRQ_ENABLE    3
`define BIT_CMP_CAPTURE       2
`define BIT_CMP_MODE_HI       1
`define BIT_CMP_MODE_LO       0

// converter control b and other bit positions
`define BIT_CMP_MUX_ENABLE    6
`define BIT_CONV_ENABLE       7
`define BIT_GLOBAL_IRQ        7
`define BIT_PIN1_BUF_OFF      1
`define BIT_PIN0_BUF_OFF      0

// writable masks and reset values
`define MASK_CONV_CONTROL_B   8'hD7
`define MASK_CMP_STATUS       8'hCF
`define RESET_BYTE            8'h00

`endif

/* File: core/cmp_ctrl_pkg.sv */
// types for the comparator control block
// assumes the cfg header sits in the include path
package cmp_ctrl_pkg;
    typedef enum logic [1:0] {
        MODE_TOGGLE,
        MODE_RESERVED,
        MODE_FALL,
        MODE_RISE
    } irq_mode_t;

    // analog routing controls handed to the comparator macro
    typedef struct packed {
        logic       powered_down;
        logic       pos_is_bandgap;
        logic       neg_is_mux;
        logic [2:0] neg_mux_channel;
    } analog_route_t;
endpackage : cmp_ctrl_pkg

/* File: core/cmp_sync.sv */
// two-flop synchroniser for the raw comparator output
// assumes the input is asynchronous to pclk
`timescale 1ns/1ns
module cmp_sync (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // raw and synchronised level
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_reg;
    logic meta_next;
    logic sync_next;

    // capture chain
    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= meta_next;
            sync_out <= sync_next;
        end
    end
endmodule : cmp_sync

/* File: core/cmp_edge_detect.sv */
// edge event detector on the synchronised comparator output
// assumes the input is already in the pclk domain
`timescale 1ns/1ns
module cmp_edge_detect
    import cmp_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic      pclk,
    input  wire logic      presetn,
    // level and mode
    input  wire logic      level,
    input  wire irq_mode_t mode,
    // one-cycle event
    output logic           event_hit
);
    logic prev_reg;
    logic prev_next;
    logic rise;
    logic fall;

    // previous-cycle compare
    always_comb begin
        prev_next = level;
        rise      = level & ~prev_reg;
        fall      = ~level & prev_reg;
        unique case (mode)
            MODE_TOGGLE:   event_hit = rise | fall;
            MODE_RESERVED: event_hit = 1'b0;
            MODE_FALL:     event_hit = fall;
            MODE_RISE:     event_hit = rise;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prev_reg <= 1'b0;
        else          prev_reg <= prev_next;
    end

    AST_RISE_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_RISE && $rose(level)) |-> event_hit)
        else $error("rise not detected");
    AST_FALL_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_FALL && $fell(level)) |-> event_hit)
        else $error("fall not detected");
    AST_TOGGLE_EVENT: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_TOGGLE && $changed(level)) |-> event_hit)
        else $error("toggle not detected");
    AST_RESERVED_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_RESERVED) |-> !event_hit)
        else $error("event in reserved mode");
    AST_EVENT_NEEDS_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
        event_hit |-> $changed(level))
        else $error("event without a level change");
endmodule : cmp_edge_detect

/* File: core/cmp_ctrl.sv */
// comparator control: apb registers, input routing, result sync, event flag
// assumes an apb master on pclk and an analog comparator outside
//
// How it works
// - the raw result passes two flops and then shows as the result bit.
// - mux enable set and converter off routes converter pin 0..7 to the negative input.
// - mux enable clear or converter on selects the dedicated negative pin.
// - bandgap select bit 6 picks the bandgap reference for the positive input.
// - disable bit 7 powers the comparator down and is writable at any time.
// - a transition matching the chosen mode sets the flag bit 4.
// - entering the interrupt vector clears the flag.
// - writing one to the flag clears it and writing zero leaves it.
// - the request stands only while flag, enable bit 3 and global enable are set.
// - mode codes are toggle, reserved, falling, rising.
// - capture enable bit 2 routes the result to the timer capture input.
// - a set buffer disable bit forces that pin's port input to zero.
// - the converter enable bit in control register a gates the negative mux.
`timescale 1ns/1ns
`include "cmp_ctrl_cfg.svh"
module cmp_ctrl
    import cmp_ctrl_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // analog comparator
    input  wire logic        cmp_raw,
    output analog_route_t    route,
    // port pins
    input  wire logic        cmp_pos_pin,
    input  wire logic        cmp_neg_pin,
    output logic             cmp_pos_port_in,
    output logic             cmp_neg_port_in,
    // interrupt and capture
    input  wire logic        vector_ack,
    output logic             irq_request,
    output logic             capture_in
);
    logic [7:0] input_disable_reg;
    logic [7:0] input_disable_next;
    logic [7:0] conv_ctrl_b_reg;
    logic [7:0] conv_ctrl_b_next;
    logic [7:0] cmp_status_reg;
    logic [7:0] cmp_status_next;
    logic [7:0] conv_ctrl_a_reg;
    logic [7:0] conv_ctrl_a_next;
    logic [7:0] conv_mux_select_reg;
    logic [7:0] conv_mux_select_next;
    logic [7:0] cpu_flags_reg;
    logic [7:0] cpu_flags_next;
    logic [31:0] prdata_next;
    logic [1:0] pin_meta_reg;
    logic [1:0] pin_sync_reg;
    logic [1:0] pin_meta_next;
    logic [1:0] pin_sync_next;
    logic       cmp_result;
    logic       event_hit;
    logic       wr_en;
    logic       rd_en;
    logic       addr_ok;
    logic       conv_enable;
    logic       cmp_mux_enable;

    // answer in the access phase with no wait
    assign pready  = 1'b1;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & ~penable & ~pwrite;

    // unmapped addresses answer with an error
    always_comb begin
        unique case (paddr)
            12'(`ADDR_OF(`IDX_INPUT_DISABLE)),
            12'(`ADDR_OF(`IDX_CONV_CONTROL_B)),
            12'(`ADDR_OF(`IDX_CMP_STATUS)),
            12'(`ADDR_OF(`IDX_CONV_CONTROL_A)),
            12'(`ADDR_OF(`IDX_CONV_MUX_SELECT)),
            12'(`ADDR_OF(`IDX_CPU_FLAGS)): addr_ok = 1'b1;
            default:                       addr_ok = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~addr_ok;

    // result synchroniser
    cmp_sync u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (cmp_raw),
        .sync_out (cmp_result)
    );

    // event detector on the synchronised result
    cmp_edge_detect u_edge (
        .pclk      (pclk),
        .presetn   (presetn),
        .level     (cmp_result),
        .mode      (irq_mode_t'(cmp_status_reg[`BIT_CMP_MODE_HI:`BIT_CMP_MODE_LO])),
        .event_hit (event_hit)
    );

    // register writes, flag set and clears
    always_comb begin
        input_disable_next   = input_disable_reg;
        conv_ctrl_b_next     = conv_ctrl_b_reg;
        cmp_status_next      = cmp_status_reg;
        conv_ctrl_a_next     = conv_ctrl_a_reg;
        conv_mux_select_next = conv_mux_select_reg;
        cpu_flags_next       = cpu_flags_reg;
        if (wr_en) begin
            unique case (paddr)
                12'(`ADDR_OF(`IDX_INPUT_DISABLE)):   input_disable_next = pwdata[7:0];
                12'(`ADDR_OF(`IDX_CONV_CONTROL_B)):
                    conv_ctrl_b_next = pwdata[7:0] & `MASK_CONV_CONTROL_B;
                12'(`ADDR_OF(`IDX_CMP_STATUS)): begin
                    // disable bit writable at any time
                    cmp_status_next = (pwdata[7:0] & `MASK_CMP_STATUS)
                                    | (cmp_status_reg & ~`MASK_CMP_STATUS);
                    if (pwdata[`BIT_CMP_IRQ_FLAG])
                        cmp_status_next[`BIT_CMP_IRQ_FLAG] = 1'b0;
                end
                12'(`ADDR_OF(`IDX_CONV_CONTROL_A)):  conv_ctrl_a_next = pwdata[7:0];
                12'(`ADDR_OF(`IDX_CONV_MUX_SELECT)): conv_mux_select_next = pwdata[7:0];
                12'(`ADDR_OF(`IDX_CPU_FLAGS)):       cpu_flags_next = pwdata[7:0];
                default: ;
            endcase
        end
        if (vector_ack)
            cmp_status_next[`BIT_CMP_IRQ_FLAG] = 1'b0;
        // a new event wins over any clear
        if (event_hit)
            cmp_status_next[`BIT_CMP_IRQ_FLAG] = 1'b1;
        cmp_status_next[`BIT_CMP_RESULT] = 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            input_disable_reg   <= `RESET_BYTE;
            conv_ctrl_b_reg     <= `RESET_BYTE;
            cmp_status_reg      <= `RESET_BYTE;
            conv_ctrl_a_reg     <= `RESET_BYTE;
            conv_mux_select_reg <= `RESET_BYTE;
            cpu_flags_reg       <= `RESET_BYTE;
        end else begin
            input_disable_reg   <= input_disable_next;
            conv_ctrl_b_reg     <= conv_ctrl_b_next;
            cmp_status_reg      <= cmp_status_next;
            conv_ctrl_a_reg     <= conv_ctrl_a_next;
            conv_mux_select_reg <= conv_mux_select_next;
            cpu_flags_reg       <= cpu_flags_next;
        end
    end

    // read data captured in the setup phase
    always_comb begin
        prdata_next = prdata;
        if (rd_en) begin
            prdata_next = 32'h0000_0000;
            unique case (paddr)
                12'(`ADDR_OF(`IDX_INPUT_DISABLE)):   prdata_next[7:0] = input_disable_reg;
                12'(`ADDR_OF(`IDX_CONV_CONTROL_B)):  prdata_next[7:0] = conv_ctrl_b_reg;
                12'(`ADDR_OF(`IDX_CMP_STATUS)): begin
                    prdata_next[7:0] = cmp_status_reg;
                    prdata_next[`BIT_CMP_RESULT] = cmp_result;
                end
                12'(`ADDR_OF(`IDX_CONV_CONTROL_A)):  prdata_next[7:0] = conv_ctrl_a_reg;
                12'(`ADDR_OF(`IDX_CONV_MUX_SELECT)): prdata_next[7:0] = conv_mux_select_reg;
                12'(`ADDR_OF(`IDX_CPU_FLAGS)):       prdata_next[7:0] = cpu_flags_reg;
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata <= 32'h0000_0000;
        else          prdata <= prdata_next;
    end

    // analog routing
    assign conv_enable    = conv_ctrl_a_reg[`BIT_CONV_ENABLE];
    assign cmp_mux_enable = conv_ctrl_b_reg[`BIT_CMP_MUX_ENABLE];
    always_comb begin
        route.powered_down    = cmp_status_reg[`BIT_CMP_DISABLE];
        route.pos_is_bandgap  = cmp_status_reg[`BIT_BANDGAP_SELECT];
        route.neg_is_mux      = cmp_mux_enable & ~conv_enable;
        route.neg_mux_channel = route.neg_is_mux ? conv_mux_select_reg[2:0] : 3'h0;
    end

    // interrupt request and capture feed
    assign irq_request = cmp_status_reg[`BIT_CMP_IRQ_FLAG]
                       & cmp_status_reg[`BIT_CMP_IRQ_ENABLE]
                       & cpu_flags_reg[`BIT_GLOBAL_IRQ];
    assign capture_in  = cmp_status_reg[`BIT_CMP_CAPTURE] & cmp_result;

    // port input synchronisers for the two comparator pins
    always_comb begin
        pin_meta_next = {cmp_neg_pin, cmp_pos_pin};
        pin_sync_next = pin_meta_reg;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_reg <= 2'h0;
            pin_sync_reg <= 2'h0;
        end else begin
            pin_meta_reg <= pin_meta_next;
            pin_sync_reg <= pin_sync_next;
        end
    end

    // buffer disable forces zero
    assign cmp_pos_port_in = pin_sync_reg[0] & ~input_disable_reg[`BIT_PIN0_BUF_OFF];
    assign cmp_neg_port_in = pin_sync_reg[1] & ~input_disable_reg[`BIT_PIN1_BUF_OFF];

    // synchroniser latency, both directions
    AST_RESULT_LATENCY: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cmp_raw) ##1 cmp_raw |=> cmp_result)
        else $error("result not synchronised in two cycles");
    AST_RESULT_FALL: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(cmp_raw) ##1 !cmp_raw |=> !cmp_result)
        else $error("result fall not synchronised in two cycles");
    AST_READ_RESULT: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_en && paddr == 12'(`ADDR_OF(`IDX_CMP_STATUS)))
            |=> prdata[`BIT_CMP_RESULT] == $past(cmp_result))
        else $error("read result bit not live");

    // negative and positive input routing
    AST_MUX_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
        (cmp_mux_enable && !conv_enable) |-> (route.neg_is_mux
            && route.neg_mux_channel == conv_mux_select_reg[2:0]))
        else $error("mux route wrong");
    AST_PIN_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
        (!cmp_mux_enable || conv_enable) |-> !route.neg_is_mux)
        else $error("dedicated pin not selected");
    AST_PIN_CHANNEL: assert property (@(posedge pclk) disable iff (!presetn)
        !route.neg_is_mux |-> route.neg_mux_channel == 3'h0)
        else $error("channel shown while dedicated pin selected");
    AST_MUX_NEEDS_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        conv_enable |-> !route.neg_is_mux)
        else $error("mux used while converter on");
    AST_BANDGAP: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == 12'(`ADDR_OF(`IDX_CMP_STATUS)))
            |=> route.pos_is_bandgap == $past(pwdata[`BIT_BANDGAP_SELECT]))
        else $error("bandgap select mismatch");
    AST_DISABLE_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == 12'(`ADDR_OF(`IDX_CMP_STATUS)))
            |=> route.powered_down == $past(pwdata[`BIT_CMP_DISABLE]))
        else $error("disable write lost");
    AST_POWER_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !(wr_en && paddr == 12'(`ADDR_OF(`IDX_CMP_STATUS)))
            |=> $stable(route.powered_down))
        else $error("disable bit changed without a write");

    // flag set and clear paths
    AST_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
        event_hit |=> cmp_status_reg[`BIT_CMP_IRQ_FLAG])
        else $error("flag not set on event");
    AST_FLAG_CAUSE: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(cmp_status_reg[`BIT_CMP_IRQ_FLAG]) |-> $past(event_hit))
        else $error("flag set without an event");
    AST_VECTOR_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        (vector_ack && !event_hit) |=> !cmp_status_reg[`BIT_CMP_IRQ_FLAG])
        else $error("flag not cleared by vector");
    AST_WRITE_ONE_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == 12'(`ADDR_OF(`IDX_CMP_STATUS)) && !event_hit)
            |=> cmp_status_reg[`BIT_CMP_IRQ_FLAG]
                == ($past(cmp_status_reg[`BIT_CMP_IRQ_FLAG])
                && !$past(pwdata[`BIT_CMP_IRQ_FLAG]) && !$past(vector_ack)))
        else $error("flag write behaviour wrong");
    AST_FLAG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (!wr_en && !vector_ack && !event_hit)
            |=> $stable(cmp_status_reg[`BIT_CMP_IRQ_FLAG]))
        else $error("flag changed with no cause");

    // request gating and capture feed
    AST_IRQ_GATE: assert property (@(posedge pclk) disable iff (!presetn)
        irq_request |-> (cmp_status_reg[`BIT_CMP_IRQ_FLAG]
            && cmp_status_reg[`BIT_CMP_IRQ_ENABLE] && cpu_flags_reg[`BIT_GLOBAL_IRQ]))
        else $error("request without all enables");
    AST_IRQ_ON: assert property (@(posedge pclk) disable iff (!presetn)
        (cmp_status_reg[`BIT_CMP_IRQ_FLAG] && cmp_status_reg[`BIT_CMP_IRQ_ENABLE]
            && cpu_flags_reg[`BIT_GLOBAL_IRQ]) |-> irq_request)
        else $error("request missing with all enables set");
    AST_CAPTURE_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        !cmp_status_reg[`BIT_CMP_CAPTURE] |-> !capture_in)
        else $error("capture driven while off");
    AST_CAPTURE_ON: assert property (@(posedge pclk) disable iff (!presetn)
        cmp_status_reg[`BIT_CMP_CAPTURE] |-> (capture_in == cmp_result))
        else $error("capture does not follow result");

    // buffer disable forces the port inputs low
    AST_BUF_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        input_disable_reg[`BIT_PIN0_BUF_OFF] |-> !cmp_pos_port_in)
        else $error("port input not forced low");
    AST_BUF_OFF_NEG: assert property (@(posedge pclk) disable iff (!presetn)
        input_disable_reg[`BIT_PIN1_BUF_OFF] |-> !cmp_neg_port_in)
        else $error("negative port input not forced low");
endmodule : cmp_ctrl

/* File: dv/test_comparator_control_logic.sv */
// self-checking bench for the comparator control block: apb, routing, events
// assumes cmp_ctrl, its package and the cfg header on the include path
`timescale 1ns/1ns
`include "cmp_ctrl_cfg.svh"
module test_comparator_control_logic;
    import cmp_ctrl_pkg::*;

    localparam int          LIMIT  = 20000;
    localparam logic [11:0] A_DIS  = 12'(`ADDR_OF(`IDX_INPUT_DISABLE));
    localparam logic [11:0] A_CTLB = 12'(`ADDR_OF(`IDX_CONV_CONTROL_B));
    localparam logic [11:0] A_STAT = 12'(`ADDR_OF(`IDX_CMP_STATUS));
    localparam logic [11:0] A_CTLA = 12'(`ADDR_OF(`IDX_CONV_CONTROL_A));
    localparam logic [11:0] A_MUX  = 12'(`ADDR_OF(`IDX_CONV_MUX_SELECT));
    localparam logic [11:0] A_CPU  = 12'(`ADDR_OF(`IDX_CPU_FLAGS));

    logic          pclk, presetn, psel, penable, pwrite, cmp_raw;
    logic          cmp_pos_pin, cmp_neg_pin, vector_ack;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata;
    logic          pready, pslverr, cmp_pos_port_in, cmp_neg_port_in;
    logic          irq_request, capture_in;
    analog_route_t route, route_exp;
    int            failures, checks, cycles, seed;
    logic [31:0]   rdata;
    logic [7:0]    rnd;
    logic          err, nm;

    cmp_ctrl dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw), .route(route),
        .cmp_pos_pin(cmp_pos_pin), .cmp_neg_pin(cmp_neg_pin),
        .cmp_pos_port_in(cmp_pos_port_in), .cmp_neg_port_in(cmp_neg_port_in),
        .vector_ack(vector_ack), .irq_request(irq_request), .capture_in(capture_in)
    );

    // clock and hang guard
    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            failures++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        if (failures == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d,
                       output logic [31:0] rd, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        // wait for the answer; only the bench timeout ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        e  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, d, rdata, err);
    endtask : wr

    task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, 8'h00, rdata, err);
        check(what, {24'h000000, exp}, rdata);
        check("pslverr", 32'h0, {31'h0, err});
    endtask : rd_chk

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : settle

    // flag expected for a given mode and edge direction
    function automatic logic flag_exp(input logic [1:0] m, input logic rise);
        case (m)
            2'b00:   return 1'b1;
            2'b10:   return !rise;
            2'b11:   return rise;
            default: return 1'b0;
        endcase
    endfunction : flag_exp

    initial begin
        {pclk, presetn, psel, penable, pwrite, cmp_raw} = '0;
        {cmp_pos_pin, cmp_neg_pin, vector_ack} = '0;
        paddr = 12'h000;
        pwdata = 32'h0;
        failures = 0;
        checks = 0;
        cycles = 0;
        seed = 72319;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // reset values
        rd_chk("dis_reset", A_DIS, 8'h00);
        rd_chk("ctlb_reset", A_CTLB, 8'h00);
        rd_chk("stat_reset", A_STAT, 8'h00);
        check("route_reset", 32'h0, 32'(route));
        check("irq_reset", 32'h0, {31'h0, irq_request});
        // random readback, unmapped place refused
        for (int i = 0; i < 6; i++) begin
            rnd = 8'($random(seed));
            wr(A_CTLB, rnd);
            rd_chk("ctlb_rw", A_CTLB, rnd & `MASK_CONV_CONTROL_B);
            rnd = 8'($random(seed));
            wr(A_DIS, rnd);
            rd_chk("dis_rw", A_DIS, rnd);
            cmp_pos_pin <= 1'($random(seed));
            cmp_neg_pin <= 1'($random(seed));
            settle(4);
            check("pos_port", {31'h0, cmp_pos_pin & ~rnd[0]}, {31'h0, cmp_pos_port_in});
            check("neg_port", {31'h0, cmp_neg_pin & ~rnd[1]}, {31'h0, cmp_neg_port_in});
        end
        apb(1'b0, 12'h3FC, 8'h00, rdata, err);
        check("unmapped_data", 32'h0, rdata);
        check("unmapped_err", 32'h1, {31'h0, err});
        check("pready", 32'h1, {31'h0, pready});
        // negative input routing over every combination
        for (int k = 0; k < 32; k++) begin
            wr(A_CTLB, {1'b0, k[4], 6'h00});
            wr(A_CTLA, {k[3], 7'h00});
            wr(A_MUX, {5'h00, k[2:0]});
            nm = k[4] & ~k[3];
            route_exp = '{1'b0, 1'b0, nm, nm ? k[2:0] : 3'h0};
            settle(0);
            check("route_neg", 32'(route_exp), 32'(route));
        end
        // positive input and power down
        for (int i = 0; i < 4; i++) begin
            wr(A_STAT, {i[1], i[0], 6'h00});
            route_exp = '{i[1], i[0], 1'b0, 3'h0};
            settle(0);
            check("route_pos", 32'(route_exp), 32'(route));
            rd_chk("stat_pos", A_STAT, {i[1], i[0], 6'h00});
        end
        wr(A_STAT, 8'h04);
        // synchroniser latency and capture routing
        @(posedge pclk);
        cmp_raw <= 1'b1;
        settle(1);
        check("capture_early", 32'h0, {31'h0, capture_in});
        settle(1);
        check("capture_late", 32'h1, {31'h0, capture_in});
        wr(A_STAT, 8'h00);
        settle(0);
        check("capture_off", 32'h0, {31'h0, capture_in});
        // every event mode with both edges, enable held clear
        for (int m = 0; m < 4; m++) begin
            for (int r = 0; r < 2; r++) begin
                @(posedge pclk);
                cmp_raw <= ~r[0];
                settle(4);
                wr(A_STAT, {3'b000, 1'b1, 2'b00, m[1:0]});
                cmp_raw <= r[0];
                settle(4);
                rd_chk("event_flag", A_STAT,
                       {2'b00, r[0], flag_exp(m[1:0], r[0]), 2'b00, m[1:0]});
            end
        end
        // flag clearing and request gating
        wr(A_STAT, 8'h10);
        cmp_raw <= 1'b0;
        settle(4);
        wr(A_STAT, 8'h08);
        rd_chk("flag_write0", A_STAT, 8'h18);
        check("irq_no_global", 32'h0, {31'h0, irq_request});
        wr(A_CPU, 8'h80);
        settle(1);
        check("irq_on", 32'h1, {31'h0, irq_request});
        @(posedge pclk);
        vector_ack <= 1'b1;
        @(posedge pclk);
        vector_ack <= 1'b0;
        settle(1);
        check("irq_after_vector", 32'h0, {31'h0, irq_request});
        rd_chk("flag_vector", A_STAT, 8'h08);
        cmp_raw <= 1'b1;
        settle(4);
        check("irq_again", 32'h1, {31'h0, irq_request});
        wr(A_STAT, 8'h18);
        settle(1);
        check("irq_write1", 32'h0, {31'h0, irq_request});
        rd_chk("flag_write1", A_STAT, 8'h28);
        wr(A_STAT, 8'h00);
        wr(A_STAT, 8'h80);
        settle(0);
        check("power_down", 32'h1, {31'h0, route.powered_down});
        settle(2);
        print_verdict();
    end
endmodule : test_comparator_control_logic
